// File: shared/lp_defines.svh
// register offsets, field positions and fixed sizes of the link port
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef LP_DEFINES_SVH
`define LP_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define LP_CTRL 8'h00
`define LP_CLKDIV 8'h04
`define LP_BLKSIZE 8'h08
`define LP_STATUS 8'h0C
`define LP_MASK 8'h10
`define LP_LEVEL 8'h14
`define LP_CKSUM 8'h18
`define LP_TXD0 8'h20
`define LP_TXD1 8'h24
`define LP_TXD2 8'h28
`define LP_TXD3 8'h2C
`define LP_RXD0 8'h30
`define LP_RXD1 8'h34
`define LP_RXD2 8'h38
`define LP_RXD3 8'h3C

// ****************************************************************
// control bits
// ****************************************************************
`define LP_C_TXEN 0
`define LP_C_RXEN 1
`define LP_C_DMA 2
`define LP_C_TXCK 3
`define LP_C_RXCK 4
`define LP_C_CHAIN 5
`define LP_CTRL_W 6

// ****************************************************************
// event bits, shared by status and mask
// ****************************************************************
`define LP_E_TXDONE 0
`define LP_E_RXDONE 1
`define LP_E_RXOVF 2
`define LP_EV_W 3

// ****************************************************************
// sizes
// ****************************************************************
`define LP_QW_W 128
`define LP_QW_BYTES 16
`define LP_QW_NIBS 5'h1F
`define LP_DIV_W 8
`define LP_BLK_W 16
`define LP_CK_W 8

`endif

// File: shared/lp_pkg.sv
// types and the checksum helper of the link port
// assumes lp_defines.svh is reachable on the include path
`include "lp_defines.svh"

package lp_pkg;

    // transmit sequencer, gray coded along idle-data-clk-done
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DATA = 2'b01,
        TX_CLK = 2'b11,
        TX_DONE = 2'b10
    } tx_state_t;

    // state of the port apart from the quad-word buffers
    typedef struct packed {
        tx_state_t st;
        logic [`LP_DIV_W-1:0] tcnt;
        logic [4:0] tnib;
        logic [`LP_QW_W-1:0] tsh;
        logic [`LP_BLK_W-1:0] tblk;
        logic [`LP_CK_W-1:0] tck;
        logic clk_o;
        logic done_o;
        logic [3:0] nib_o;
        logic [`LP_QW_W-1:0] rsh;
        logic [4:0] rnib;
        logic rclk_p;
        logic rbcmp_p;
        logic rnew;
        logic [`LP_CK_W-1:0] rck;
        logic ack_o;
        logic [`LP_CTRL_W-1:0] ctrl;
        logic [`LP_DIV_W-1:0] div;
        logic [`LP_BLK_W-1:0] blksz;
        logic [`LP_EV_W-1:0] stat;
        logic [`LP_EV_W-1:0] mask;
        logic irq;
        logic [95:0] stage;
        logic tdma_rdy;
        logic rdma_vld;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lp_state_t;

    // byte sum of one quad-word
    function automatic logic [`LP_CK_W-1:0] qw_sum(
        input logic [`LP_QW_W-1:0] w);
        logic [`LP_CK_W-1:0] s;
        s = '0;
        for (int i = 0; i < `LP_QW_BYTES; i++) begin
            s = s + w[8*i +: 8];
        end
        return s;
    endfunction

endpackage

// File: hw/qw_fifo.sv
// quad-word shift buffer; entry zero is always the oldest word
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none

module qw_fifo #(
    parameter int W = 128,
    parameter int DEPTH = 2,
    parameter int CW = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic push,
    input wire logic [W-1:0] din,
    input wire logic pop,
    output logic [W-1:0] head,
    output logic [CW-1:0] count
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [CW-1:0] cnt;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;

    // pop shifts toward entry zero, push lands behind the last word
    always_comb begin
        d = q;
        if (pop && q.cnt != '0) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.mem[i] = q.mem[i+1];
            end
            d.cnt = q.cnt - 1'b1;
        end
        if (push && d.cnt < CW'(DEPTH)) begin
            d.mem[d.cnt] = din;
            d.cnt = d.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign head = q.mem[0];
    assign count = q.cnt;

endmodule // qw_fifo

`default_nettype wire

// File: hw/link_port.sv
// full-duplex nibble link port with apb registers and dma handshakes
// assumes pclk is the on-chip bus clock, half the core clock, and that
// link inputs arrive synchronous to pclk
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module link_port
    import lp_pkg::*;
#(
    parameter int TX_DEPTH = 2,
    parameter int RX_DEPTH = 3,
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic tx_dma_valid,
    input wire logic [`LP_QW_W-1:0] tx_dma_data,
    output logic tx_dma_ready,
    output logic rx_dma_valid,
    output logic [`LP_QW_W-1:0] rx_dma_data,
    input wire logic rx_dma_ready,
    output logic tx_link_clock_out,
    output logic [3:0] tx_nibble_out,
    input wire logic tx_flow_ack_in,
    output logic tx_block_done_out,
    input wire logic rx_link_clock_in,
    input wire logic [3:0] rx_nibble_in,
    output logic rx_flow_ack_out,
    input wire logic rx_block_done_in
);

    localparam int CW = 2;

    lp_state_t q;
    lp_state_t d;

    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [`LP_QW_W-1:0] tx_din;
    logic [`LP_QW_W-1:0] rx_din;
    logic [`LP_QW_W-1:0] tx_head;
    logic [`LP_QW_W-1:0] rx_head;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] rx_cnt;
    logic [`LP_EV_W-1:0] ev;
    logic [`LP_EV_W-1:0] clr;
    logic [31:0] rd;
    logic map_ok;
    logic fin;
    logic [7:0] a;
    logic dma;

    // ****************************************************************
    // quad-word buffers
    // ****************************************************************

    // transmit double buffer
    qw_fifo #(.W(`LP_QW_W), .DEPTH(TX_DEPTH), .CW(CW)) u_txbuf (
        .pclk(pclk),
        .presetn(presetn),
        .push(tx_push),
        .din(tx_din),
        .pop(tx_pop),
        .head(tx_head),
        .count(tx_cnt)
    );

    // receive triple buffer
    qw_fifo #(.W(`LP_QW_W), .DEPTH(RX_DEPTH), .CW(CW)) u_rxbuf (
        .pclk(pclk),
        .presetn(presetn),
        .push(rx_push),
        .din(rx_din),
        .pop(rx_pop),
        .head(rx_head),
        .count(rx_cnt)
    );

    // ****************************************************************
    // register read mux
    // ****************************************************************

    // read value and decode of the current address
    always_comb begin
        a = 8'(paddr);
        rd = '0;
        map_ok = 1'b1;
        unique case (a)
            `LP_CTRL: rd = 32'(q.ctrl);
            `LP_CLKDIV: rd = 32'(q.div);
            `LP_BLKSIZE: rd = 32'(q.blksz);
            `LP_STATUS: rd = 32'(q.stat);
            `LP_MASK: rd = 32'(q.mask);
            `LP_LEVEL: rd = {24'h00_0000, 2'b00, rx_cnt, 2'b00, tx_cnt};
            `LP_CKSUM: rd = {16'h0000, q.rck, q.tck};
            `LP_TXD0, `LP_TXD1, `LP_TXD2, `LP_TXD3: rd = '0;
            `LP_RXD0: rd = rx_head[31:0];
            `LP_RXD1: rd = rx_head[63:32];
            `LP_RXD2: rd = rx_head[95:64];
            `LP_RXD3: rd = rx_head[127:96];
            default: map_ok = 1'b0;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************

    always_comb begin
        d = q;
        dma = q.ctrl[`LP_C_DMA];
        fin = psel && penable && q.pready;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_din = tx_head;
        rx_din = {rx_nibble_in, q.rsh[`LP_QW_W-1:4]};
        ev = '0;
        clr = '0;

        // apb: one wait state, a core push stalls while tx is full
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            if (!(pwrite && a == `LP_TXD3 && !dma &&
                  int'(tx_cnt) >= TX_DEPTH)) begin
                d.pready = 1'b1;
                d.prdata = rd;
                d.pslverr = !map_ok ||
                    (!pwrite && a == `LP_RXD3 && rx_cnt == '0);
            end
        end

        // register writes take effect on the completing edge
        if (fin && pwrite) begin
            unique case (a)
                `LP_CTRL: d.ctrl = pwdata[`LP_CTRL_W-1:0];
                `LP_CLKDIV: d.div = pwdata[`LP_DIV_W-1:0];
                `LP_BLKSIZE: d.blksz = pwdata[`LP_BLK_W-1:0];
                `LP_STATUS: clr = pwdata[`LP_EV_W-1:0];
                `LP_MASK: d.mask = pwdata[`LP_EV_W-1:0];
                `LP_TXD0: d.stage[31:0] = pwdata;
                `LP_TXD1: d.stage[63:32] = pwdata;
                `LP_TXD2: d.stage[95:64] = pwdata;
                `LP_TXD3: begin
                    tx_din = {pwdata, q.stage};
                    tx_push = !dma;
                end
                default: ;
            endcase
        end

        // core read of the last receive word frees the entry
        if (fin && !pwrite && a == `LP_RXD3 && !dma) begin
            rx_pop = 1'b1;
        end

        // dma channels, one each way
        if (dma && q.tdma_rdy && tx_dma_valid) begin
            tx_din = tx_dma_data;
            tx_push = 1'b1;
        end
        if (dma && q.rdma_vld && rx_dma_ready) begin
            rx_pop = 1'b1;
        end

        // transmit sequencer: data set up, then the clock edge
        unique case (q.st)
            TX_IDLE: begin
                if (q.ctrl[`LP_C_TXEN] && tx_cnt != '0 &&
                    tx_flow_ack_in) begin
                    tx_pop = 1'b1;
                    d.tsh = tx_head;
                    d.nib_o = tx_head[3:0];
                    d.tnib = '0;
                    d.tcnt = q.div;
                    d.st = TX_DATA;
                    // checksum restarts per block unless chained
                    if (q.tblk == '0 && !q.ctrl[`LP_C_CHAIN]) begin
                        d.tck = '0;
                    end
                    if (q.ctrl[`LP_C_TXCK]) begin
                        d.tck = d.tck + qw_sum(tx_head);
                    end
                end
            end
            TX_DATA: begin
                if (q.tcnt == '0) begin
                    d.clk_o = !q.clk_o;
                    d.tcnt = q.div;
                    d.st = TX_CLK;
                end else begin
                    d.tcnt = q.tcnt - 1'b1;
                end
            end
            TX_CLK: begin
                if (q.tcnt != '0) begin
                    d.tcnt = q.tcnt - 1'b1;
                end else if (q.tnib == `LP_QW_NIBS) begin
                    if (q.tblk == q.blksz) begin
                        d.tblk = '0;
                        d.done_o = 1'b1;
                        d.tcnt = q.div;
                        d.st = TX_DONE;
                    end else begin
                        d.tblk = q.tblk + 1'b1;
                        d.st = TX_IDLE;
                    end
                end else begin
                    d.tsh = {4'h0, q.tsh[`LP_QW_W-1:4]};
                    d.nib_o = q.tsh[7:4];
                    d.tnib = q.tnib + 1'b1;
                    d.tcnt = q.div;
                    d.st = TX_DATA;
                end
            end
            TX_DONE: begin
                if (q.tcnt == '0) begin
                    d.done_o = 1'b0;
                    ev[`LP_E_TXDONE] = 1'b1;
                    d.st = TX_IDLE;
                end else begin
                    d.tcnt = q.tcnt - 1'b1;
                end
            end
        endcase

        // receiver: a nibble on every change of the far-end clock
        d.rclk_p = rx_link_clock_in;
        if (q.ctrl[`LP_C_RXEN] &&
            (rx_link_clock_in != q.rclk_p)) begin
            d.rsh = rx_din;
            d.rnib = q.rnib + 1'b1;
            if (q.rnib == `LP_QW_NIBS) begin
                d.rnib = '0;
                rx_push = 1'b1;
                if (int'(rx_cnt) >= RX_DEPTH && !rx_pop) begin
                    ev[`LP_E_RXOVF] = 1'b1;
                end
                if (q.rnew && !q.ctrl[`LP_C_CHAIN]) begin
                    d.rck = '0;
                end
                d.rnew = 1'b0;
                if (q.ctrl[`LP_C_RXCK]) begin
                    d.rck = d.rck + qw_sum(rx_din);
                end
            end
        end

        // far-end block end closes the block, drops a partial word
        d.rbcmp_p = rx_block_done_in;
        if (q.ctrl[`LP_C_RXEN] && rx_block_done_in &&
            !q.rbcmp_p) begin
            ev[`LP_E_RXDONE] = 1'b1;
            d.rnew = 1'b1;
            d.rnib = '0;
        end

        // ack stays high while at least two more quad-words still fit
        d.ack_o = q.ctrl[`LP_C_RXEN] &&
            (int'(rx_cnt) + int'(rx_push) - int'(rx_pop)
             < RX_DEPTH - 1);

        // dma handshakes follow the next buffer level
        d.tdma_rdy = d.ctrl[`LP_C_DMA] &&
            (int'(tx_cnt) + int'(tx_push) - int'(tx_pop) < TX_DEPTH);
        d.rdma_vld = d.ctrl[`LP_C_DMA] &&
            (int'(rx_cnt) + int'(rx_push) - int'(rx_pop) > 0);

        // sticky events, a new event beats a clear
        d.stat = (q.stat & ~clr) | ev;
        d.irq = |(d.stat & d.mask);
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    // single clock domain, everything on pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;
    assign tx_dma_ready = q.tdma_rdy;
    assign rx_dma_valid = q.rdma_vld;
    assign rx_dma_data = rx_head;
    assign tx_link_clock_out = q.clk_o;
    assign tx_nibble_out = q.nib_o;
    assign tx_block_done_out = q.done_o;
    assign rx_flow_ack_out = q.ack_o;

endmodule // link_port

`default_nettype wire

// File: dv/far_link.sv
// far-end link port model: collects our transmit words, sends words back
// assumes link signals change on pclk edges, as the port samples them
`timescale 1ns/10ps
`default_nettype none

module far_link (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_in,
    input wire logic [3:0] nib_in,
    input wire logic hold,
    output logic ack_out,
    output logic clk_out,
    output logic [3:0] nib_out,
    output logic done_out,
    input wire logic ack_in,
    input wire logic rude,
    output logic [127:0] word,
    output logic [7:0] nwords
);
    // ********************
    // receiver
    // ********************
    logic clk_p;
    logic [4:0] cnt;
    logic [127:0] sh;

    // room for a quad-word unless the bench stalls us
    assign ack_out = !hold;

    // one nibble on each edge of the incoming clock, low nibble first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_p <= 1'b0;
            cnt <= '0;
            sh <= '0;
            word <= '0;
            nwords <= '0;
        end else begin
            clk_p <= clk_in;
            if (clk_in != clk_p) begin
                sh <= {nib_in, sh[127:4]};
                cnt <= cnt + 5'h1;
                if (cnt == 5'h1f) begin
                    word <= {nib_in, sh[127:4]};
                    nwords <= nwords + 8'h01;
                end
            end
        end
    end

    // ********************
    // transmitter
    // ********************
    initial begin
        clk_out = 1'b0;
        nib_out = 4'h0;
        done_out = 1'b0;
    end

    // one quad-word; waits for room unless told to be rude
    task automatic send(input logic [127:0] w);
        int k;
        k = 0;
        while (ack_in !== 1'b1 && !rude && k < 500) begin
            k++;
            @(posedge pclk);
        end
        for (int i = 0; i < 32; i++) begin
            nib_out <= w[4*i +: 4];
            @(posedge pclk);
            clk_out <= ~clk_out;
            @(posedge pclk);
        end
        nib_out <= ~w[127:124]; // line no longer held
        repeat (3) @(posedge pclk);
    endtask

    // block end marker
    task automatic bdone;
        done_out <= 1'b1;
        repeat (2) @(posedge pclk);
        done_out <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // far_link

`default_nettype wire

// File: dv/link_port_asserts.sv
// pin-level checks of the link port: apb answers, link timing, dma hold
// assumes it is bound to every link_port instance
`timescale 1ns/10ps
`default_nettype none

module link_port_chk #(
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_dma_valid,
    input wire logic [127:0] rx_dma_data,
    input wire logic rx_dma_ready,
    input wire logic tx_link_clock_out,
    input wire logic [3:0] tx_nibble_out,
    input wire logic tx_block_done_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ********************
    // register bus
    // ********************
    property p_rdy_cause;
        pready |-> $past(psel) && $past(penable);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause)
        else $error("pready without an access");

    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("pready longer than one cycle");

    property p_err_with;
        pslverr |-> pready;
    endproperty
    a_err_with: assert property (p_err_with)
        else $error("pslverr without pready");

    property p_unmapped;
        psel && penable && !pready && paddr > 8'h3C
            |=> pready && pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_cfg_ok;
        psel && penable && !pready && paddr < 8'h1C && paddr[1:0] == 2'h0
            |=> pready && !pslverr;
    endproperty
    a_cfg_ok: assert property (p_cfg_ok)
        else $error("config access late or refused");

    // ********************
    // link and dma
    // ********************
    property p_ddr;
        $changed(tx_link_clock_out) |-> $stable(tx_nibble_out);
    endproperty
    a_ddr: assert property (p_ddr)
        else $error("nibble moved with the link clock");

    property p_done_still;
        tx_block_done_out |-> $stable(tx_link_clock_out);
    endproperty
    a_done_still: assert property (p_done_still)
        else $error("link clock moved during block done");

    property p_done_len;
        $rose(tx_block_done_out) |-> ##[1:256] !tx_block_done_out;
    endproperty
    a_done_len: assert property (p_done_len)
        else $error("block done stuck high");

    property p_dma_hold;
        rx_dma_valid && !rx_dma_ready |=> rx_dma_valid && $stable(rx_dma_data);
    endproperty
    a_dma_hold: assert property (p_dma_hold)
        else $error("receive dma word dropped before taken");
endmodule // link_port_chk

bind link_port link_port_chk #(.AW(AW)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_dma_valid(rx_dma_valid), .rx_dma_data(rx_dma_data),
    .rx_dma_ready(rx_dma_ready), .tx_link_clock_out(tx_link_clock_out),
    .tx_nibble_out(tx_nibble_out), .tx_block_done_out(tx_block_done_out)
);

`default_nettype wire

// File: dv/link_port_bench.sv
// self-checking bench of the link port: registers, link, irq and dma
// assumes far_link on the link pins and the bound pin checker
`timescale 1ns/10ps
`default_nettype none
`include "lp_defines.svh"

module link_port_bench;
    localparam logic [127:0] W0 = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    localparam logic [127:0] W1 = 128'hf0e1_d2c3_b4a5_9687_7869_5a4b_3c2d_1e0f;
    logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, rxr = 1'b0, txv = 1'b0, hold = 1'b0, rude = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [127:0] txd = '0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, irq, txr, rxv, tck, ack, rck, rdn, rack, tdn, rerr;
    logic [127:0] rxd, fw;
    logic [3:0] tnib, rnib;
    logic [7:0] fn;
    int n_errors = 0, n_tests = 0, nbd = 0;

    always #12.5 pclk = ~pclk;
    always @(posedge tdn) nbd++;

    link_port dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .tx_dma_valid(txv), .tx_dma_data(txd), .tx_dma_ready(txr),
        .rx_dma_valid(rxv), .rx_dma_data(rxd), .rx_dma_ready(rxr),
        .tx_link_clock_out(tck), .tx_nibble_out(tnib),
        .tx_flow_ack_in(ack), .tx_block_done_out(tdn),
        .rx_link_clock_in(rck), .rx_nibble_in(rnib),
        .rx_flow_ack_out(rack), .rx_block_done_in(rdn)
    );
    far_link far (
        .pclk(pclk), .presetn(presetn), .clk_in(tck), .nib_in(tnib),
        .hold(hold), .ack_out(ack), .clk_out(rck), .nib_out(rnib),
        .done_out(rdn), .ack_in(rack), .rude(rude), .word(fw), .nwords(fn)
    );

    // ********************
    // shared tasks
    // ********************
    task automatic chk(input string s, input logic [127:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    // one apb transfer, held until pready, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 200 && pready !== 1'b1; k++) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input string s);
        apb(1'b0, a, '0);
        chk(s, x, rdat);
    endtask

    task automatic wq(input logic [127:0] w);
        for (int i = 0; i < 4; i++) wr(`LP_TXD0 + 8'(4*i), w[32*i +: 32]);
    endtask

    task automatic rq(input logic [127:0] w);
        for (int i = 0; i < 4; i++) rd(`LP_RXD0 + 8'(4*i), w[32*i +: 32], "rxd");
    endtask

    task automatic wfar(input logic [7:0] n);
        for (int k = 0; k < 2000 && fn !== n; k++) @(posedge pclk);
        chk("far words", n, fn);
    endtask

    task automatic irqc(input logic e);
        repeat (2) @(posedge pclk);
        chk("irq", e, irq);
    endtask

    function automatic logic [7:0] bsum(input logic [127:0] w);
        logic [7:0] s;
        s = '0;
        for (int i = 0; i < 16; i++) s += w[8*i +: 8];
        return s;
    endfunction

    // ********************
    // scenarios
    // ********************
    task automatic t_regs;
        rd(`LP_CTRL, '0, "ctrl reset");
        wr(`LP_CLKDIV, 32'h0000_00a5);
        rd(`LP_CLKDIV, 32'h0000_00a5, "clkdiv");
        wr(`LP_BLKSIZE, 32'h0001_2345);
        rd(`LP_BLKSIZE, 32'h0000_2345, "blksize");
        rd(8'h40, '0, "unmapped");
        chk("unmapped err", 1'b1, rerr);
        rd(`LP_TXD0, '0, "txd read");
    endtask

    // two-word block at divisor 1, checksum, done event and irq
    task automatic t_tx;
        wr(`LP_CLKDIV, 32'h0000_0001);
        wr(`LP_BLKSIZE, 32'h0000_0001);
        wr(`LP_MASK, 32'h0000_0001);
        wr(`LP_CTRL, 32'h0000_0009);
        wq(W0);
        wq(W1);
        wfar(8'h01);
        chk("first word", W0, fw);
        wfar(8'h02);
        chk("second word", W1, fw);
        repeat (10) @(posedge pclk);
        chk("block done", 1, nbd);
        rd(`LP_STATUS, 32'h0000_0001, "tx done");
        rd(`LP_CKSUM, {24'h00_0000, bsum(W0) + bsum(W1)}, "tx sum");
        irqc(1'b1);
        wr(`LP_MASK, '0);
        irqc(1'b0);
        wr(`LP_MASK, 32'h0000_0001);
        irqc(1'b1);
        wr(`LP_STATUS, 32'h0000_0001);
        irqc(1'b0);
    endtask

    // far end not ready: the word must wait
    task automatic t_stall;
        hold <= 1'b1;
        wr(`LP_BLKSIZE, '0);
        wq(W1);
        repeat (60) @(posedge pclk);
        chk("stalled", 8'h02, fn);
        hold <= 1'b0;
        wfar(8'h03);
        chk("resumed word", W1, fw);
        // let block done and its event finish before clearing
        repeat (10) @(posedge pclk);
        wr(`LP_STATUS, 32'h0000_0007);
    endtask

    // far end ignores flow control: three held, fourth dropped
    task automatic t_rx;
        wr(`LP_CTRL, 32'h0000_0002);
        rude <= 1'b1;
        far.send(W0);
        far.send(W1);
        far.send(W0);
        far.send(W1);
        rude <= 1'b0;
        chk("rx ack full", 1'b0, rack);
        rd(`LP_STATUS, 32'h0000_0004, "overflow");
        rd(`LP_LEVEL, 32'h0000_0030, "rx level");
        rq(W0);
        rq(W1);
        rq(W0);
        chk("rx ack free", 1'b1, rack);
        apb(1'b0, `LP_RXD3, '0);
        chk("empty read err", 1'b1, rerr);
        far.bdone;
        rd(`LP_STATUS, 32'h0000_0006, "rx done");
        wr(`LP_STATUS, 32'h0000_0006);
    endtask

    // both dma channels while both directions run
    task automatic t_dma;
        int k;
        wr(`LP_CTRL, 32'h0000_0007);
        txv <= 1'b1;
        txd <= W0;
        fork
            far.send(W1);
            begin
                @(posedge pclk);
                for (k = 0; k < 99 && txr !== 1'b1; k++) @(posedge pclk);
                txv <= 1'b0;
            end
        join
        chk("dma rx valid", 1'b1, rxv);
        chk("dma rx word", W1, rxd);
        rxr <= 1'b1;
        @(posedge pclk);
        rxr <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("dma rx popped", 1'b0, rxv);
        wfar(8'h04);
        chk("dma tx word", W0, fw);
    endtask

    // ********************
    // run control
    // ********************
    task automatic test_done;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        test_done;
    end

    initial begin
        // a falling edge at time zero so the async reset really fires
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_tx;
        t_stall;
        t_rx;
        t_dma;
        test_done;
    end
endmodule // link_port_bench

`default_nettype wire
